// ===== core/ext_dispatch_pkg.sv
// Constants and types for the extension-instruction dispatch block.
// Assumes a single 250 MHz clock and an Avalon-MM register slave.
package ext_dispatch_pkg;
    // Instruction field positions
    localparam int FLD_A_HI = 31;
    localparam int FLD_A_LO = 27;
    localparam int FLD_B_HI = 26;
    localparam int FLD_B_LO = 22;
    localparam int FLD_C_HI = 21;
    localparam int FLD_C_LO = 17;
    localparam int BIT_READ_A = 16;
    localparam int BIT_READ_B = 15;
    localparam int BIT_WRITE_C = 14;
    localparam int FLD_SEL_HI = 13;
    localparam int FLD_SEL_LO = 6;
    localparam int FLD_OP_HI = 5;
    localparam int FLD_OP_LO = 0;
    // Major opcode that marks an extension instruction (arbitrary value)
    localparam logic [5:0] EXT_OPCODE = 6'h01;

    // Register byte offsets
    localparam logic [7:0] OFS_INSTR = 8'h00;
    localparam logic [7:0] OFS_STATUS = 8'h04;
    localparam logic [7:0] OFS_RESULT = 8'h08;
    localparam logic [7:0] OFS_GPR_BASE = 8'h80;
    // Status bit positions
    localparam int ST_BUSY = 0;
    localparam int ST_BAD_OP = 1;
    localparam int ST_OVERRUN = 2;
    localparam int ST_SEL_LO = 8;
    // Reset values
    localparam logic [31:0] RST_WORD = 32'h0000_0000;

    typedef enum logic [0:0] {
        ST_IDLE = 1'b0,
        ST_WAIT = 1'b1
    } disp_state_t;

    // Request towards the user extension logic
    typedef struct packed {
        logic start;
        logic [7:0] sel;
        logic [4:0] idx_a;
        logic [4:0] idx_b;
        logic [4:0] idx_c;
        logic read_a;
        logic read_b;
        logic write_c;
        logic [31:0] data_a;
        logic [31:0] data_b;
    } ext_req_t;
endpackage : ext_dispatch_pkg

// ===== core/ext_dispatch.sv
// Dispatch of user extension instructions, with the general register file.
// The custom register file lives in the user logic, not here.
// Every bus access answers after one wait state.
// Assumes an Avalon-MM master and user logic that pulses done once per start.
//
// Register access over Avalon-MM and the placing of the registers were decided locally.
module ext_dispatch (
    input wire logic clock_i,
    input wire logic rst_i,
    input wire logic [7:0] avs_address_i,
    input wire logic avs_read_i,
    input wire logic avs_write_i,
    input wire logic [31:0] avs_writedata_i,
    input wire logic [3:0] avs_byteenable_i,
    output logic [31:0] avs_readdata_o,
    output logic avs_waitrequest_o,
    output ext_dispatch_pkg::ext_req_t ext_req_o,
    input wire logic ext_done_i,
    input wire logic [31:0] ext_result_i
);
    import ext_dispatch_pkg::*;

    // Merge write data into an old word under byte enables
    function automatic logic [31:0] merge_bytes(input logic [31:0] old_w,
                                                input logic [31:0] new_w,
                                                input logic [3:0] be);
        logic [31:0] res;
        res = old_w;
        for (int i = 0; i < 4; i++) begin
            if (be[i]) begin
                res[i*8 +: 8] = new_w[i*8 +: 8];
            end
        end
        return res;
    endfunction : merge_bytes

    // Register index A of an instruction word
    function automatic logic [4:0] field_a(input logic [31:0] w);
        return w[FLD_A_HI:FLD_A_LO];
    endfunction : field_a

    // Register index B of an instruction word
    function automatic logic [4:0] field_b(input logic [31:0] w);
        return w[FLD_B_HI:FLD_B_LO];
    endfunction : field_b

    // Register index C of an instruction word
    function automatic logic [4:0] field_c(input logic [31:0] w);
        return w[FLD_C_HI:FLD_C_LO];
    endfunction : field_c

    // Function selector of an instruction word
    function automatic logic [7:0] field_sel(input logic [31:0] w);
        return w[FLD_SEL_HI:FLD_SEL_LO];
    endfunction : field_sel

    // General operand when its flag is set, zero when the custom file supplies it
    function automatic logic [31:0] pick_operand(input logic from_gpr,
                                                 input logic [31:0] gpr_val);
        return from_gpr ? gpr_val : RST_WORD;
    endfunction : pick_operand

    // Accepted status write with a one in the given flag position
    function automatic logic clear_hit(input logic take,
                                       input logic [7:0] addr,
                                       input logic [31:0] data,
                                       input int pos);
        return take && addr == OFS_STATUS && data[pos] == 1'b1;
    endfunction : clear_hit

    logic [31:0] gpr [32];
    disp_state_t state;
    logic ack;
    logic bad_op;
    logic overrun;
    logic [31:0] last_result;
    logic [31:0] instr_word;
    logic bus_req;
    logic wr_take;
    logic rd_take;
    logic is_gpr;
    logic [4:0] gpr_idx;
    logic instr_wr;
    logic instr_ok;
    logic wb_fire;
    logic [31:0] op_a;
    logic [31:0] op_b;
    logic [31:0] status_now;

    // Bus answers on the cycle after the request is seen
    assign bus_req = avs_read_i | avs_write_i;
    assign avs_waitrequest_o = bus_req & ~ack;
    assign wr_take = avs_write_i & ack;
    assign rd_take = avs_read_i & ~ack;
    assign is_gpr = avs_address_i[7];
    assign gpr_idx = avs_address_i[6:2];
    assign instr_wr = wr_take && avs_address_i == OFS_INSTR;

    // Instruction word, missing bytes read as zero
    assign instr_word = merge_bytes(RST_WORD, avs_writedata_i, avs_byteenable_i);
    assign instr_ok = instr_word[FLD_OP_HI:FLD_OP_LO] == EXT_OPCODE;

    // Write-back moment: the extension logic answers while busy
    assign wb_fire = state == ST_WAIT && ext_done_i;

    // Operand words as they stand when the instruction is accepted
    assign op_a = pick_operand(instr_word[BIT_READ_A], gpr[field_a(instr_word)]);
    assign op_b = pick_operand(instr_word[BIT_READ_B], gpr[field_b(instr_word)]);

    // Status word: last selector, sticky flags and busy
    assign status_now = {16'h0000, ext_req_o.sel, 5'h00, overrun, bad_op, state == ST_WAIT};

    // Handshake toggle for the bus
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            ack <= 1'b0;
        end else begin
            ack <= bus_req & ~ack;
        end
    end

    // Read data captured one cycle ahead of the answer
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            avs_readdata_o <= RST_WORD;
        end else if (rd_take) begin
            if (is_gpr) begin
                avs_readdata_o <= gpr[gpr_idx];
            end else begin
                case (avs_address_i)
                    OFS_STATUS: avs_readdata_o <= status_now;
                    OFS_INSTR: avs_readdata_o <= RST_WORD; // Write-only register
                    OFS_RESULT: avs_readdata_o <= last_result;
                    default: avs_readdata_o <= RST_WORD;
                endcase
            end
        end
    end

    // Dispatch sequencer and request towards the extension logic
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            state <= ST_IDLE;
            ext_req_o <= '0;
        end else begin
            ext_req_o.start <= 1'b0;
            case (state)
                ST_IDLE: begin
                    if (instr_wr && instr_ok) begin
                        ext_req_o.start <= 1'b1;
                        ext_req_o.sel <= field_sel(instr_word);
                        ext_req_o.idx_a <= field_a(instr_word);
                        ext_req_o.idx_b <= field_b(instr_word);
                        ext_req_o.idx_c <= field_c(instr_word);
                        // Source and destination flags travel with the request
                        ext_req_o.read_a <= instr_word[BIT_READ_A];
                        ext_req_o.read_b <= instr_word[BIT_READ_B];
                        ext_req_o.write_c <= instr_word[BIT_WRITE_C];
                        // Two operands at most, custom ones left to the far side
                        ext_req_o.data_a <= op_a;
                        ext_req_o.data_b <= op_b;
                        state <= ST_WAIT;
                    end
                end
                ST_WAIT: begin
                    if (ext_done_i) begin
                        state <= ST_IDLE;
                    end
                end
                default: state <= ST_IDLE;
            endcase
        end
    end

    // Last result as seen from the extension logic
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            last_result <= RST_WORD;
        end else if (wb_fire) begin
            last_result <= ext_result_i;
        end
    end

    // General register file: write-back beats a bus write
    always_ff @(posedge clock_i) begin
        if (wb_fire && ext_req_o.write_c) begin
            gpr[ext_req_o.idx_c] <= ext_result_i;
            // A bus write landing in the same cycle is lost
        end else if (wr_take && is_gpr) begin
            gpr[gpr_idx] <= merge_bytes(gpr[gpr_idx], avs_writedata_i, avs_byteenable_i);
        end
    end

    // Sticky bad-opcode flag, a new event wins over a clear
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            bad_op <= 1'b0;
        end else if (instr_wr && !instr_ok) begin
            bad_op <= 1'b1;
        end else if (clear_hit(wr_take, avs_address_i, avs_writedata_i, ST_BAD_OP)) begin
            bad_op <= 1'b0;
        end
    end

    // Sticky overrun flag, a new event wins over a clear
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            overrun <= 1'b0;
        end else if (instr_wr && instr_ok && state == ST_WAIT) begin
            overrun <= 1'b1;
        end else if (clear_hit(wr_take, avs_address_i, avs_writedata_i, ST_OVERRUN)) begin
            overrun <= 1'b0;
        end
    end
endmodule : ext_dispatch

// ===== tb/ext_dispatch_props.sv
// Checker on the dispatch block ports.
// Assumes binding to the dispatch module.
module ext_dispatch_props import ext_dispatch_pkg::*; (
    input wire logic clock_i,
    input wire logic rst_i,
    input wire logic [7:0] avs_address_i,
    input wire logic avs_write_i,
    input wire logic [31:0] avs_writedata_i,
    input wire logic [3:0] avs_byteenable_i,
    input wire logic avs_waitrequest_o,
    input ext_req_t ext_req_o,
    input wire logic ext_done_i
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge clock_i); endclocking
    default disable iff (rst_i);
    logic busy;
    logic take;
    logic [31:0] wd;
    ext_req_t q;
    // One instruction in flight; an answer in the start cycle ends it at once
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            busy <= 1'b0;
        end else if (ext_done_i) begin
            busy <= 1'b0;
        end else if (ext_req_o.start) begin
            busy <= 1'b1;
        end
    end
    // Accepted write to the instruction register, absent bytes read as zero
    assign wd = avs_writedata_i & {{8{avs_byteenable_i[3]}}, {8{avs_byteenable_i[2]}},
                                   {8{avs_byteenable_i[1]}}, {8{avs_byteenable_i[0]}}};
    assign q = ext_req_o;
    assign take = avs_write_i && !avs_waitrequest_o && avs_address_i == OFS_INSTR
        && !busy && !q.start;
    sequence s_take; take && wd[5:0] == EXT_OPCODE; endsequence
    property p_sel; s_take |=> q.start && q.sel == $past(wd[13:6]); endproperty
    property p_a; s_take |=> q.read_a == $past(wd[16]) && q.idx_a == $past(wd[31:27]); endproperty
    property p_b; s_take |=> q.read_b == $past(wd[15]) && q.idx_b == $past(wd[26:22]); endproperty
    property p_c; s_take |=> q.write_c == $past(wd[14]) && q.idx_c == $past(wd[21:17]); endproperty
    property p_bad; take && wd[5:0] != EXT_OPCODE |=> !q.start; endproperty
    property p_zero; q.start |-> (q.read_a || q.data_a == 0)
        && (q.read_b || q.data_b == 0); endproperty
    property p_one; busy && !ext_done_i |=> !q.start; endproperty
    a_sel: assert property (p_sel) else $error("bad selector");
    a_a: assert property (p_a) else $error("bad operand A");
    a_b: assert property (p_b) else $error("bad operand B");
    a_c: assert property (p_c) else $error("bad result target");
    a_bad: assert property (p_bad) else $error("foreign opcode sent");
    a_zero: assert property (p_zero) else $error("custom operand leak");
    a_one: assert property (p_one) else $error("second start");
endmodule : ext_dispatch_props
bind ext_dispatch ext_dispatch_props ext_dispatch_props_inst (.*);

// ===== tb/ext_model.sv
// Behavioural user extension logic.
// Assumes lag_i stays steady while an instruction runs.
module ext_model import ext_dispatch_pkg::*; (
    input wire logic clock_i,
    input wire logic rst_i,
    input ext_req_t req_i,
    input wire logic [1:0] lag_i,
    output logic done_o,
    output logic [31:0] result_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [3:0] sr;
    logic [31:0] r;
    // Answer after lag, result scrambled outside done
    assign done_o = sr[lag_i];
    assign result_o = done_o ? r : ~r;
    // Two operands in, one result out
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            sr <= 4'h0;
            r <= 32'h0;
        end else begin
            sr <= {sr[2:0], req_i.start};
            if (req_i.start) r <= {req_i.sel, 24'h0} ^ req_i.data_a ^ {req_i.data_b[30:0], 1'b0};
        end
    end
endmodule : ext_model

// ===== tb/tb_top.sv
// Bench for the dispatch block.
// Assumes the extension model on the far side.
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import ext_dispatch_pkg::*;
    logic clock_i = 0, rst_i = 1, rd = 0, wr = 0, wt, done;
    logic [7:0] ad = 0;
    logic [1:0] lag = 0;
    logic [3:0] be = 4'hf;
    logic [7:0] sel_last = 0;
    logic [31:0] wd = 0, rdat, res, ins, ea, eb, ex, gpr[32], q[$];
    ext_req_t req;
    int err_total = 0, samples_checked = 0, i;
    ext_dispatch ext_dispatch_inst (.clock_i, .rst_i, .avs_address_i(ad), .avs_read_i(rd),
        .avs_write_i(wr), .avs_writedata_i(wd), .avs_byteenable_i(be),
        .avs_readdata_o(rdat), .avs_waitrequest_o(wt), .ext_req_o(req), .ext_done_i(done),
        .ext_result_i(res));
    ext_model ext_model_inst (.clock_i, .rst_i, .req_i(req), .lag_i(lag), .done_o(done),
        .result_o(res));
    // Clock
    always #2 clock_i = ~clock_i;
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clock_i);
        ad <= a;
        wd <= d;
        wr <= w;
        rd <= !w;
        do @(posedge clock_i); while (wt !== 1'b0);
        wr <= 0;
        rd <= 0;
    endtask : bus
    task automatic get(input logic [7:0] a, input logic [31:0] e);
        q.push_back(e);
        bus(0, a, 0);
    endtask : get
    task automatic cmp(input logic [31:0] g, input logic [31:0] e);
        samples_checked++;
        if (g !== e) begin
            err_total++;
            $display("BAD %0t read %h want %h", $time, g, e);
        end
    endtask : cmp
    // Match each read answer to the oldest note
    always @(posedge clock_i) if (rd && wt === 1'b0) cmp(rdat, q.pop_front());
    // Main sequence
    initial begin
        void'($urandom(32'hffa5a9df));
        repeat (4) @(posedge clock_i);
        rst_i <= 0;
        for (i = 0; i < 32; i++) begin
            gpr[i] = $urandom;
            bus(1, 8'h80 + 8'(i * 4), gpr[i]);
        end
        get(8'hfc, gpr[31]);
        // Partial write: only the low two bytes of r5 change
        ins = $urandom;
        be <= 4'h3;
        bus(1, 8'h94, ins);
        be <= 4'hf;
        gpr[5][15:0] = ins[15:0];
        get(8'h94, gpr[5]);
        $display("test load done");
        for (i = 0; i < 9; i++) begin
            ins = $urandom;
            ins[16:14] = 3'(i);
            ins[5:0] = i < 8 ? EXT_OPCODE : 6'h3e;
            lag <= 2'($urandom);
            ea = ins[16] ? gpr[ins[31:27]] : 0;
            eb = ins[15] ? gpr[ins[26:22]] : 0;
            if (i < 8) ex = {ins[13:6], 24'h0} ^ ea ^ {eb[30:0], 1'b0};
            if (i < 8) sel_last = ins[13:6];
            if (i < 8 && ins[14]) gpr[ins[21:17]] = ex;
            bus(1, OFS_INSTR, ins);
            // A foreign opcode gets no answer, so only a fixed pause
            if (i < 8) begin
                while (done !== 1'b1) @(posedge clock_i);
            end else begin
                repeat (9) @(posedge clock_i);
            end
            get(OFS_RESULT, ex);
            get(8'h80 + {1'b0, ins[21:17], 2'b00}, gpr[ins[21:17]]);
        end
        $display("test dispatch done");
        get(OFS_STATUS, {16'h0000, sel_last, 8'h00} | (32'h1 << ST_BAD_OP));
        bus(1, OFS_STATUS, 32'h1 << ST_BAD_OP);
        get(OFS_STATUS, {16'h0000, sel_last, 8'h00});
        $display("test status done");
        // Second instruction while the first still runs is refused
        lag <= 2'd3;
        ins = $urandom;
        ins[16:14] = 3'b110;
        ins[5:0] = EXT_OPCODE;
        ex = {ins[13:6], 24'h0} ^ gpr[ins[31:27]] ^ {gpr[ins[26:22]][30:0], 1'b0};
        sel_last = ins[13:6];
        bus(1, OFS_INSTR, ins);
        bus(1, OFS_INSTR, ins ^ 32'h0000_3fc0);
        while (done !== 1'b1) @(posedge clock_i);
        get(OFS_RESULT, ex);
        get(OFS_STATUS, {16'h0000, sel_last, 8'h00} | (32'h1 << ST_OVERRUN));
        bus(1, OFS_STATUS, 32'h1 << ST_OVERRUN);
        get(OFS_STATUS, {16'h0000, sel_last, 8'h00});
        $display("test overrun done");
        bus(1, 8'h40, $urandom);
        get(8'h40, 0);
        $display("test unmapped done");
        final_report;
    end
    // Watchdog
    initial begin
        #4000;
        err_total++;
        final_report;
    end
    task automatic final_report;
        $display("checked %0d errors %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask : final_report
endmodule : tb_top
